/* File: pfs_pkg.sv */
// constants for the pin function selection block: register map, command codes,
// field layout, mode codes and timing counts.
// assumes a 20 MHz system clock and a single AHB-Lite master.
`default_nettype none
package pfs_pkg;
    // geometry
    localparam int AXES          = 4;
    localparam int PINS          = 8;
    localparam int SEL_W         = 2;
    localparam int SET_W         = 16;
    localparam int DS_W          = 8;
    localparam int SYNC_CH       = 4;
    localparam int CMP_CH        = 4;
    localparam int EXT_PLUS_PIN  = 4;
    localparam int EXT_MINUS_PIN = 5;

    // register byte offsets
    localparam logic [7:0] OFF_CMD_DATA   = 8'h00;
    localparam logic [7:0] OFF_CMD_CODE   = 8'h04;
    localparam logic [7:0] OFF_OUT_FIRST  = 8'h08;
    localparam logic [7:0] OFF_OUT_SECOND = 8'h0c;
    localparam logic [7:0] OFF_IN_FIRST   = 8'h10;
    localparam logic [7:0] OFF_IN_SECOND  = 8'h14;
    localparam logic [7:0] OFF_STATUS     = 8'h18;
    localparam logic [3:0] OFF_PINFN_HI   = 4'h2;
    localparam logic [3:0] OFF_CMPMD_HI   = 4'h3;

    // command register fields
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_AXIS_LSB = 8;
    localparam logic [7:0] CMD_CMP_MODE = 8'h20;
    localparam logic [7:0] CMD_PIN_FUNC = 8'h21;

    // status register fields
    localparam int STAT_BUSY_BIT = 0;

    // reset values
    localparam logic [15:0] PIN_FUNC_RST = 16'h0000;
    localparam logic [15:0] CMP_MODE_RST = 16'h0000;
    localparam logic [15:0] OUT_RST      = 16'h0000;

    // command acceptance time, longest figure rounded down, at least one cycle
    localparam int CLK_KHZ      = 20000;
    localparam int CMD_TIME_NS  = 125;
    localparam int CMD_BUSY_RAW = (CMD_TIME_NS * CLK_KHZ) / 1000000;
    localparam int CMD_BUSY_CYC = (CMD_BUSY_RAW < 1) ? 1 : CMD_BUSY_RAW;
    localparam int BUSY_W       = 3;

    // per-pin function codes
    typedef enum logic [1:0] {
        PFS_MODE_IN   = 2'b00,
        PFS_MODE_OUT  = 2'b01,
        PFS_MODE_DRV  = 2'b10,
        PFS_MODE_SYNC = 2'b11
    } pfs_mode_t;
endpackage
`default_nettype wire

/* File: pfs_pin_mux.sv */
// per-axis output source selection for eight multi-purpose pins.
// assumes pin_level is already synchronised to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_mux (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [15:0] pin_function_setting,
    input  wire logic [7:0]  out_value,
    input  wire logic [7:0]  drive_status,
    input  wire logic [3:0]  sync_pulse,
    input  wire logic [3:0]  cmp_result,
    input  wire logic [7:0]  pin_level,
    output var  logic [7:0]  io_out,
    output var  logic [7:0]  io_oe,
    output var  logic [7:0]  trig_rise,
    output var  logic [7:0]  trig_fall,
    output var  logic        ext_plus,
    output var  logic        ext_minus
);
    logic [7:0] level_prev_q;
    logic [7:0] in_mode;
    logic [2:0] warm_q;

    // decode which pins sit in general input mode
    always_comb begin
        for (int k = 0; k < pfs_pkg::PINS; k++) begin
            in_mode[k] = (pin_function_setting[2*k +: 2] == pfs_pkg::PFS_MODE_IN);
        end
    end

    // synchroniser warm-up, hides the false edge while the chain fills after reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            warm_q <= 3'b000;
        end else begin
            warm_q <= {warm_q[1:0], 1'b1};
        end
    end

    // previous level for edge detection
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            level_prev_q <= 8'h00;
        end else begin
            level_prev_q <= pin_level;
        end
    end

    // output source and enable per pin, switched on the next edge after a new setting
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            io_out <= 8'h00;
            io_oe  <= 8'h00;
        end else begin
            for (int k = 0; k < pfs_pkg::PINS; k++) begin
                case (pfs_pkg::pfs_mode_t'(pin_function_setting[2*k +: 2]))
                    pfs_pkg::PFS_MODE_IN: begin
                        io_out[k] <= 1'b0;
                        io_oe[k]  <= 1'b0;
                    end
                    pfs_pkg::PFS_MODE_OUT: begin
                        io_out[k] <= out_value[k];
                        io_oe[k]  <= 1'b1;
                    end
                    pfs_pkg::PFS_MODE_DRV: begin
                        io_out[k] <= drive_status[k];
                        io_oe[k]  <= 1'b1;
                    end
                    pfs_pkg::PFS_MODE_SYNC: begin
                        io_out[k] <= (k < pfs_pkg::SYNC_CH) ? sync_pulse[k % 4] : cmp_result[k % 4];
                        io_oe[k]  <= 1'b1;
                    end
                    default: begin
                        io_out[k] <= 1'b0;
                        io_oe[k]  <= 1'b0;
                    end
                endcase
            end
        end
    end

    // edge triggers and external drive inputs, only in input mode
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trig_rise <= 8'h00;
            trig_fall <= 8'h00;
            ext_plus  <= 1'b0;
            ext_minus <= 1'b0;
        end else begin
            trig_rise <= {8{warm_q[2]}} & in_mode & pin_level & ~level_prev_q;
            trig_fall <= {8{warm_q[2]}} & in_mode & ~pin_level & level_prev_q;
            ext_plus  <= in_mode[pfs_pkg::EXT_PLUS_PIN] & pin_level[pfs_pkg::EXT_PLUS_PIN];
            ext_minus <= in_mode[pfs_pkg::EXT_MINUS_PIN] & pin_level[pfs_pkg::EXT_MINUS_PIN];
        end
    end
endmodule
`default_nettype wire

/* File: pfs_top.sv */
// top of the pin function selection block: AHB-Lite register slave, command
// execution, pin synchronisers and four per-axis pin multiplexers.
// assumes one AHB-Lite master on clk_sys, pins asynchronous, status inputs on clk_sys.
// Function
// - command 21h with two data bytes sets the selected axes' pin functions
// - reset clears all sixteen setting bits, every pin becomes an input
// - pin k uses select bits 2k+1 and 2k
// - code 00: pin input, levels readable in the two input read registers
// - code 01: pin driven from the two output write registers
// - output mode drives low for a 0 bit, high for a 1 bit
// - code 10: pins 0..3 show driving, error, accelerating, constant speed
// - code 11: pins 3..0 sync pulse channels, pins 7..4 comparator results
// - comparator object and condition come from the 20h command setting
// - input mode pins give rising and falling edge triggers
// - input mode pins 4 and 5 act as external drive inputs
`timescale 1ns/1ps
`default_nettype none
module pfs_top (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    input  wire logic [31:0] io_in,
    output wire logic [31:0] io_out,
    output wire logic [31:0] io_oe,
    input  wire logic [31:0] drive_status,
    input  wire logic [15:0] sync_pulse,
    input  wire logic [15:0] cmp_result,
    output var  logic [63:0] comparator_mode,
    output wire logic [31:0] sync_trig_rise,
    output wire logic [31:0] sync_trig_fall,
    output wire logic [3:0]  ext_drive_plus,
    output wire logic [3:0]  ext_drive_minus
);
    logic [31:0] io_meta_q;
    logic [31:0] io_sync_q;
    logic        wr_pend_q;
    logic [7:0]  waddr_q;
    logic [15:0] cmd_data_q;
    logic [15:0] out_first_q;
    logic [15:0] out_second_q;
    logic [15:0] pin_func_q [4];
    logic [15:0] cmp_mode_q [4];
    logic [2:0]  busy_cnt_q;
    logic        busy;
    logic        addr_take;
    logic        cmd_strobe;
    logic [7:0]  cmd_code;
    logic [3:0]  cmd_axes;
    logic [7:0]  raddr;

    assign busy       = (busy_cnt_q != 3'd0);
    assign addr_take  = hsel & htrans[1] & hready;
    assign cmd_strobe = wr_pend_q & (waddr_q == pfs_pkg::OFF_CMD_CODE) & ~busy;
    assign cmd_code   = hwdata[pfs_pkg::CMD_CODE_LSB +: 8];
    assign cmd_axes   = hwdata[pfs_pkg::CMD_AXIS_LSB +: 4];
    assign raddr      = {haddr[7:2], 2'b00};

    // two-flop synchroniser on the pins
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            io_meta_q <= 32'h0000_0000;
            io_sync_q <= 32'h0000_0000;
        end else begin
            io_meta_q <= io_in;
            io_sync_q <= io_meta_q;
        end
    end

    // zero-wait slave, always okay
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // address phase capture for writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            waddr_q   <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= addr_take & hwrite;
            waddr_q   <= raddr;
        end
    end

    // read data registered at the address phase edge, unmapped reads zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take & ~hwrite) begin
            if (raddr[7:4] == pfs_pkg::OFF_PINFN_HI) begin
                hrdata <= {16'h0000, pin_func_q[raddr[3:2]]};
            end else if (raddr[7:4] == pfs_pkg::OFF_CMPMD_HI) begin
                hrdata <= {16'h0000, cmp_mode_q[raddr[3:2]]};
            end else begin
                case (raddr)
                    pfs_pkg::OFF_OUT_FIRST:  hrdata <= {16'h0000, out_first_q};
                    pfs_pkg::OFF_OUT_SECOND: hrdata <= {16'h0000, out_second_q};
                    pfs_pkg::OFF_IN_FIRST:   hrdata <= {16'h0000, io_sync_q[15:0]};
                    pfs_pkg::OFF_IN_SECOND:  hrdata <= {16'h0000, io_sync_q[31:16]};
                    pfs_pkg::OFF_STATUS:     hrdata <= {31'h0000_0000, busy};
                    default:                 hrdata <= 32'h0000_0000;
                endcase
            end
        end else begin
            hrdata <= 32'h0000_0000;
        end
    end

    // command data register, ignored while a command is being accepted
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_data_q <= 16'h0000;
        end else if (wr_pend_q & (waddr_q == pfs_pkg::OFF_CMD_DATA) & ~busy) begin
            cmd_data_q <= hwdata[15:0];
        end
    end

    // output write registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_first_q  <= pfs_pkg::OUT_RST;
            out_second_q <= pfs_pkg::OUT_RST;
        end else if (wr_pend_q) begin
            if (waddr_q == pfs_pkg::OFF_OUT_FIRST) begin
                out_first_q <= hwdata[15:0];
            end
            if (waddr_q == pfs_pkg::OFF_OUT_SECOND) begin
                out_second_q <= hwdata[15:0];
            end
        end
    end

    // acceptance window after a command; further command data and code writes are dropped meanwhile
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_cnt_q <= 3'd0;
        end else if (cmd_strobe) begin
            busy_cnt_q <= 3'(pfs_pkg::CMD_BUSY_CYC);
        end else if (busy) begin
            busy_cnt_q <= busy_cnt_q - 3'd1;
        end
    end

    // command execution into per-axis mode setting registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int a = 0; a < pfs_pkg::AXES; a++) begin
                pin_func_q[a] <= pfs_pkg::PIN_FUNC_RST;
                cmp_mode_q[a] <= pfs_pkg::CMP_MODE_RST;
            end
        end else if (cmd_strobe) begin
            for (int a = 0; a < pfs_pkg::AXES; a++) begin
                if (cmd_axes[a] && cmd_code == pfs_pkg::CMD_PIN_FUNC) begin
                    pin_func_q[a] <= cmd_data_q;
                end
                if (cmd_axes[a] && cmd_code == pfs_pkg::CMD_CMP_MODE) begin
                    cmp_mode_q[a] <= cmd_data_q;
                end
            end
        end
    end

    // comparator settings handed to the comparator logic
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            comparator_mode <= 64'h0000_0000_0000_0000;
        end else begin
            comparator_mode <= {cmp_mode_q[3], cmp_mode_q[2], cmp_mode_q[1], cmp_mode_q[0]};
        end
    end

    // one pin multiplexer per axis: x, y take first registers low/high, z, u second
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_axis
            logic [7:0] out_value;
            assign out_value = (g == 0) ? out_first_q[7:0] :
                               (g == 1) ? out_first_q[15:8] :
                               (g == 2) ? out_second_q[7:0] : out_second_q[15:8];
            pfs_pin_mux u_mux (
                .clk_sys              (clk_sys),
                .rst                  (rst),
                .pin_function_setting (pin_func_q[g]),
                .out_value            (out_value),
                .drive_status         (drive_status[8*g +: 8]),
                .sync_pulse           (sync_pulse[4*g +: 4]),
                .cmp_result           (cmp_result[4*g +: 4]),
                .pin_level            (io_sync_q[8*g +: 8]),
                .io_out               (io_out[8*g +: 8]),
                .io_oe                (io_oe[8*g +: 8]),
                .trig_rise            (sync_trig_rise[8*g +: 8]),
                .trig_fall            (sync_trig_fall[8*g +: 8]),
                .ext_plus             (ext_drive_plus[g]),
                .ext_minus            (ext_drive_minus[g])
            );
        end
    endgenerate

    // hsize is a whole word by contract
    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:8], haddr[1:0], hwdata[31:16]};
endmodule
`default_nettype wire

/* File: pfs_top_checker.sv */
// assertions on the pin function block, seeing only the top module ports.
// assumes hready is tied to hreadyout and the host waits out the busy flag.
`timescale 1ns/1ps
`default_nettype none
module pfs_top_checker (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] io_in,
    input wire logic [31:0] io_out,
    input wire logic [31:0] io_oe,
    input wire logic [31:0] drive_status,
    input wire logic [15:0] sync_pulse,
    input wire logic [15:0] cmp_result,
    input wire logic [63:0] comparator_mode,
    input wire logic [31:0] sync_trig_rise,
    input wire logic [31:0] sync_trig_fall,
    input wire logic [3:0]  ext_drive_plus,
    input wire logic [3:0]  ext_drive_minus
);
    logic        wr_q;
    logic [7:0]  a_q;
    logic [15:0] dat_q;
    logic [63:0] set_q, cmp_q, md_q;
    logic [31:0] ow_q, in_q, ex_d, ex_q, m_out, m_drv, m_syn, oe_x;
    logic [3:0]  in4, in5;
    logic [2:0]  qt_q;
    // shadow of command data, settings and output registers from bus writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_q <= 1'b0;
            a_q <= 8'h00;
            dat_q <= 16'h0000;
            set_q <= 64'h0;
            cmp_q <= 64'h0;
            ow_q <= 32'h0;
        end else begin
            wr_q <= hsel & htrans[1] & hready & hwrite;
            if (hsel & htrans[1] & hready) a_q <= haddr[7:0];
            if (wr_q && a_q == pfs_pkg::OFF_CMD_DATA) dat_q <= hwdata[15:0];
            if (wr_q && a_q == pfs_pkg::OFF_OUT_FIRST) ow_q[15:0] <= hwdata[15:0];
            if (wr_q && a_q == pfs_pkg::OFF_OUT_SECOND) ow_q[31:16] <= hwdata[15:0];
            for (int a = 0; a < 4; a++) begin
                if (wr_q && a_q == pfs_pkg::OFF_CMD_CODE && hwdata[8+a]) begin
                    if (hwdata[7:0] == pfs_pkg::CMD_PIN_FUNC) set_q[16*a+:16] <= dat_q;
                    if (hwdata[7:0] == pfs_pkg::CMD_CMP_MODE) cmp_q[16*a+:16] <= dat_q;
                end
            end
        end
    end
    // expected pin drive per mode, and masks from the applied setting
    always_comb begin
        for (int p = 0; p < 32; p++) begin
            case (set_q[2*p+:2])
                2'b01:   ex_d[p] = ow_q[p];
                2'b10:   ex_d[p] = drive_status[p];
                2'b11:   ex_d[p] = (p % 8 < 4) ? sync_pulse[4*(p/8)+p%4] : cmp_result[4*(p/8)+p%4];
                default: ex_d[p] = 1'b0;
            endcase
            oe_x[p] = |md_q[2*p+:2];
            m_out[p] = md_q[2*p+:2] == 2'b01;
            m_drv[p] = md_q[2*p+:2] == 2'b10;
            m_syn[p] = md_q[2*p+:2] == 2'b11;
        end
        for (int a = 0; a < 4; a++) begin
            in4[a] = md_q[16*a+8+:2] == 2'b00;
            in5[a] = md_q[16*a+10+:2] == 2'b00;
        end
    end
    // one-cycle lag and a count of cycles with pins and setting quiet
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            md_q <= 64'h0;
            ex_q <= 32'h0;
            in_q <= 32'h0;
            qt_q <= 3'd0;
        end else begin
            md_q <= set_q;
            ex_q <= ex_d;
            in_q <= io_in;
            if (io_in != in_q || set_q != md_q) qt_q <= 3'd0;
            else if (qt_q != 3'd7) qt_q <= qt_q + 3'd1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_RESET_IDLE: assert property ($fell(rst) |-> io_oe == 32'h0)
        else $error("pins enabled right after reset");
    AST_OE_MODE: assert property (io_oe == oe_x)
        else $error("output enable disagrees with pin mode");
    AST_GPO: assert property (((io_out ^ ex_q) & m_out) == 32'h0)
        else $error("output pin differs from output register");
    AST_DRV: assert property (((io_out ^ ex_q) & m_drv) == 32'h0)
        else $error("status pin differs from drive status");
    AST_SYNC: assert property (((io_out ^ ex_q) & m_syn) == 32'h0)
        else $error("pulse or compare pin wrong");
    AST_CMP_MODE: assert property (comparator_mode == $past(cmp_q))
        else $error("comparator mode not the last setting");
    AST_EXT: assert property (qt_q >= 3'd4 |->
        ((ext_drive_plus ^ {io_in[28], io_in[20], io_in[12], io_in[4]}) & in4) == 4'h0 &&
        ((ext_drive_minus ^ {io_in[29], io_in[21], io_in[13], io_in[5]}) & in5) == 4'h0)
        else $error("external drive input not following pin");
    AST_TRIG_QUIET: assert property (qt_q >= 3'd4 |-> sync_trig_rise == 32'h0 && sync_trig_fall == 32'h0)
        else $error("edge trigger with quiet pins");
    AST_TRIG_PULSE: assert property ((sync_trig_rise & $past(sync_trig_rise)) == 32'h0)
        else $error("rise trigger longer than one cycle");
    AST_TRIG_MODE: assert property (((sync_trig_rise | sync_trig_fall) & oe_x) == 32'h0)
        else $error("edge trigger on a pin not in input mode");
endmodule
bind pfs_top pfs_top_checker chk_u (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .drive_status(drive_status), .sync_pulse(sync_pulse),
    .cmp_result(cmp_result), .comparator_mode(comparator_mode), .sync_trig_rise(sync_trig_rise),
    .sync_trig_fall(sync_trig_fall), .ext_drive_plus(ext_drive_plus), .ext_drive_minus(ext_drive_minus));
`default_nettype wire

/* File: pfs_far_model.sv */
// far side model: pin pads and motor driver status sources.
// assumes clk_sys is the device clock; a driven pin reads back its own drive.
`timescale 1ns/1ps
`default_nettype none
module pfs_far_model (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [31:0] io_out,
    input  wire logic [31:0] io_oe,
    input  wire logic [31:0] ext_level,
    output var  logic [31:0] io_in,
    output var  logic [31:0] drive_status,
    output var  logic [15:0] sync_pulse,
    output var  logic [15:0] cmp_result
);
    logic [31:0] cnt_q;
    // status sources change every cycle so latency slips show
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_q + 32'h9e37_79b9;
        end
    end
    // pad level: device drive where enabled, sensor level elsewhere
    always_comb begin
        io_in = (io_out & io_oe) | (ext_level & ~io_oe);
        drive_status = cnt_q;
        sync_pulse = cnt_q[31:16];
        cmp_result = cnt_q[15:0];
    end
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the pin function block over its register bus.
// assumes zero wait state slave; checker is bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_sys, rst, hsel, hwrite;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, ext_level;
    logic        hreadyout, hresp;
    logic [31:0] hrdata, io_in, io_out, io_oe, ds, tr, tf;
    logic [15:0] sp, cr;
    logic [63:0] cm;
    logic [3:0]  ep, em;
    int          miscompares, total_checks;
    pfs_top dut_u (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .drive_status(ds), .sync_pulse(sp), .cmp_result(cr), .comparator_mode(cm),
        .sync_trig_rise(tr), .sync_trig_fall(tf), .ext_drive_plus(ep), .ext_drive_minus(em));
    pfs_far_model far_u (.clk_sys(clk_sys), .rst(rst), .io_out(io_out), .io_oe(io_oe),
        .ext_level(ext_level), .io_in(io_in), .drive_status(ds), .sync_pulse(sp), .cmp_result(cr));
    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait for hready at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (n >= 40) begin
            miscompares++;
            close_out();
        end
    endtask
    // one single transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    // data first, then code; busy seen, then waited out
    task automatic cmd(input logic [7:0] code, input logic [3:0] m, input logic [15:0] d);
        logic [31:0] q;
        int n;
        wr(pfs_pkg::OFF_CMD_DATA, {16'h0, d});
        wr(pfs_pkg::OFF_CMD_CODE, {20'h0, m, code});
        rd_chk(pfs_pkg::OFF_STATUS, 32'h1);
        n = 0;
        do begin
            bus(1'b0, pfs_pkg::OFF_STATUS, 32'h0, q);
            n++;
        end while (q[0] !== 1'b0 && n < 10);
        chk(q & 32'h1, 32'h0);
        if (q[0] !== 1'b0) begin
            close_out();
        end
    endtask
    task automatic t_reset();
        for (int a = 0; a < 4; a++) rd_chk(8'h20 + 8'(4 * a), 32'h0);
        rd_chk(pfs_pkg::OFF_OUT_FIRST, 32'h0);
        chk(io_oe, 32'h0);
    endtask
    task automatic t_modes();
        logic [15:0] pat [4];
        pat = '{16'he4e4, 16'h5555, 16'haaaa, 16'hffff};
        for (int a = 0; a < 4; a++) begin
            cmd(pfs_pkg::CMD_PIN_FUNC, 4'(1 << a), pat[a]);
            rd_chk(8'h20 + 8'(4 * a), {16'h0, pat[a]});
        end
        cmd(pfs_pkg::CMD_PIN_FUNC, 4'h0, 16'h0);
        rd_chk(8'h20, {16'h0, pat[0]});
        wr(8'h20, 32'h0);
        rd_chk(8'h20, {16'h0, pat[0]});
        wr(8'h40, 32'hffff_ffff);
        rd_chk(8'h40, 32'h0);
        wr(pfs_pkg::OFF_OUT_FIRST, 32'h0000_c35a);
        wr(pfs_pkg::OFF_OUT_SECOND, 32'h0000_0f96);
        rd_chk(pfs_pkg::OFF_OUT_SECOND, 32'h0000_0f96);
        repeat (2) @(posedge clk_sys);
        chk(io_oe, 32'hffff_ffee);
        chk(io_out & 32'h0000_ff22, 32'h0000_c302);
    endtask
    task automatic t_cmp();
        cmd(pfs_pkg::CMD_CMP_MODE, 4'ha, 16'h9c3a);
        rd_chk(8'h34, 32'h0000_9c3a);
        rd_chk(8'h30, 32'h0);
        chk(cm[63:32], 32'h9c3a_0000);
        chk(cm[31:0], 32'h9c3a_0000);
    endtask
    task automatic t_inputs();
        int r, f;
        cmd(pfs_pkg::CMD_PIN_FUNC, 4'hf, 16'h0);
        repeat (4) @(posedge clk_sys);
        chk(io_oe, 32'h0);
        rd_chk(pfs_pkg::OFF_IN_FIRST, 32'h0000_96f0);
        rd_chk(pfs_pkg::OFF_IN_SECOND, 32'h0000_4a3c);
        chk({28'h0, ep}, 32'h7);
        chk({28'h0, em}, 32'h5);
        for (int s = 0; s < 2; s++) begin
            ext_level <= ext_level ^ 32'h1;
            r = 0;
            f = 0;
            repeat (8) begin
                @(posedge clk_sys);
                r += (tr[0] === 1'b1);
                f += (tf[0] === 1'b1);
            end
            chk(32'(r), 32'(1 - s));
            chk(32'(f), 32'(s));
        end
    endtask
    // system clock, 50 ns period
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // reset, then the scenarios in order
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        ext_level = 32'h4a3c_96f0;
        miscompares = 0;
        total_checks = 0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_modes();
        t_cmp();
        t_inputs();
        close_out();
    end
endmodule
`default_nettype wire
